// ==== rtl/apl_pkg.sv ====
package apl_pkg;

    // ==========================================
    // widths and field positions
    localparam int POS_W = 32;
    localparam int TURN_W = 16;
    localparam int PULSE_W = 24;
    localparam int AXIS_TYPE_BIT = 0;
    localparam int MAX_PRODUCT_W = 64;

    // ==========================================
    // reset values
    localparam logic [POS_W-1:0] POS_RESET = 32'h0000_0000;
    localparam logic [TURN_W-1:0] TURN_RESET = 16'h0000;
    localparam logic [PULSE_W-1:0] PULSE_RESET = 24'h00_0000;

    // ==========================================
    // axis handling modes
    typedef enum logic [1:0] {
        APL_AXIS_FINITE = 2'b00,
        APL_AXIS_SIMPLE_INF = 2'b01,
        APL_AXIS_PLAIN_INF = 2'b10
    } apl_axis_e;

    typedef enum logic [2:0] {
        APL_IDLE = 3'b000,
        APL_REQ = 3'b001,
        APL_WAIT = 3'b010,
        APL_CALC = 3'b011,
        APL_DONE = 3'b100
    } apl_state_e;

    // absolute data answer from the drive
    typedef struct packed {
        logic [TURN_W-1:0] multi_turn;
        logic [PULSE_W-1:0] initial_pulse_offset;
    } apl_abs_data_s;

    // per-axis configuration
    typedef struct packed {
        logic [15:0] fixed_param1;
        logic simple_inf_en;
        logic [POS_W-1:0] pulses_per_rev;
        logic [15:0] gear_num;
        logic [15:0] gear_den;
        logic [POS_W-1:0] home_offset_param;
        logic [POS_W-1:0] wrap_len;
    } apl_cfg_s;

endpackage : apl_pkg

// ==== rtl/apl_divider.sv ====
// ==========================================
// sequential restoring divider, unsigned, one quotient bit per clock
module apl_divider #(
    parameter int W = 64
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [W-1:0] dividend_i,
    input wire logic [W-1:0] divisor_i,
    output logic busy_o,
    output logic done_o,
    output logic [W-1:0] quotient_o,
    output logic [W-1:0] remainder_o
);
    if (W < 2) begin : g_width_check
        $error("apl_divider: width too small");
    end

    logic [W-1:0] quot;
    logic [W-1:0] rem;
    logic [W-1:0] dvs;
    logic [$clog2(W+1)-1:0] cnt;
    logic busy;
    logic done;
    logic [W-1:0] next_quot;
    logic [W-1:0] next_rem;
    logic [W-1:0] next_dvs;
    logic [$clog2(W+1)-1:0] next_cnt;
    logic next_busy;
    logic next_done;

    always_comb begin
        logic [W:0] trial;
        trial = '0;
        next_quot = quot;
        next_rem = rem;
        next_dvs = dvs;
        next_cnt = cnt;
        next_busy = busy;
        next_done = 1'b0;
        if (start_i && !busy) begin
            next_quot = dividend_i;
            next_rem = '0;
            next_dvs = divisor_i;
            next_cnt = ($clog2(W+1))'(W);
            next_busy = 1'b1;
        end else if (busy) begin
            trial = {rem, quot[W-1]} - {1'b0, dvs};
            if (!trial[W]) begin
                next_rem = trial[W-1:0];
                next_quot = {quot[W-2:0], 1'b1};
            end else begin
                next_rem = {rem[W-2:0], quot[W-1]};
                next_quot = {quot[W-2:0], 1'b0};
            end
            next_cnt = cnt - 1'b1;
            if (cnt == 1) begin
                next_busy = 1'b0;
                next_done = 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            quot <= '0;
            rem <= '0;
            dvs <= '0;
            cnt <= '0;
            busy <= 1'b0;
            done <= 1'b0;
        end else begin
            quot <= next_quot;
            rem <= next_rem;
            dvs <= next_dvs;
            cnt <= next_cnt;
            busy <= next_busy;
            done <= next_done;
        end
    end

    assign busy_o = busy;
    assign done_o = done;
    assign quotient_o = quot;
    assign remainder_o = rem;
endmodule : apl_divider

// ==== rtl/apl_absolute_position_loader.sv ====
module apl_absolute_position_loader #(
    parameter int POS_W = apl_pkg::POS_W,
    parameter int TURN_W = apl_pkg::TURN_W,
    parameter int PULSE_W = apl_pkg::PULSE_W
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic link_up_i,
    input wire logic abs_data_valid_i,
    input wire apl_pkg::apl_abs_data_s abs_data_i,
    input wire apl_pkg::apl_cfg_s cfg_i,
    input wire logic home_return_cmd_i,
    output logic abs_data_req_o,
    output logic [POS_W-1:0] machine_pos_o,
    output logic coord_valid_o,
    output logic auto_run_ok_o,
    output apl_pkg::apl_axis_e axis_mode_o,
    output logic busy_o
);
    if (POS_W != apl_pkg::POS_W || TURN_W != apl_pkg::TURN_W || PULSE_W != apl_pkg::PULSE_W) begin : g_width_check
        $error("apl_absolute_position_loader: widths must match the package structs");
    end

    localparam int PW = apl_pkg::MAX_PRODUCT_W;

    // ==========================================
    // link input synchroniser
    logic link_meta;
    logic link_sync;

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            link_meta <= 1'b0;
            link_sync <= 1'b0;
        end else begin
            link_meta <= link_up_i;
            link_sync <= link_meta;
        end
    end

    // ==========================================
    // sequencer
    apl_pkg::apl_state_e state;
    apl_pkg::apl_state_e next_state;
    apl_pkg::apl_abs_data_s held;
    apl_pkg::apl_abs_data_s next_held;
    logic got_early;
    logic next_got_early;
    logic req;
    logic next_req;
    logic [1:0] step;
    logic [1:0] next_step;
    logic [PW-1:0] acc;
    logic [PW-1:0] next_acc;
    logic [POS_W-1:0] pos;
    logic [POS_W-1:0] next_pos;
    logic valid;
    logic next_valid;
    logic auto_ok;
    logic next_auto_ok;
    apl_pkg::apl_axis_e mode;
    apl_pkg::apl_axis_e next_mode;
    // sign of the ungeared position, kept while the magnitude is divided
    logic neg;
    logic next_neg;
    logic busy;
    logic next_busy;
    logic div_start;
    logic div_done;
    logic [PW-1:0] div_q;
    logic [PW-1:0] div_r;
    logic [PW-1:0] div_a;
    logic [PW-1:0] div_b;

    apl_divider #(.W(PW)) u_div (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .start_i(div_start),
        .dividend_i(div_a),
        .divisor_i(div_b),
        .busy_o(),
        .done_o(div_done),
        .quotient_o(div_q),
        .remainder_o(div_r)
    );

    always_comb begin
        next_state = state;
        next_held = held;
        next_got_early = got_early;
        next_req = 1'b0;
        next_step = step;
        next_acc = acc;
        next_pos = pos;
        next_valid = valid;
        next_auto_ok = auto_ok;
        next_mode = mode;
        next_neg = neg;
        next_busy = 1'b0;
        div_start = 1'b0;
        div_a = acc;
        div_b = '0;
        if (abs_data_valid_i && state != apl_pkg::APL_CALC && state != apl_pkg::APL_DONE) begin
            next_held = abs_data_i;
            next_got_early = 1'b1;
        end
        unique case (state)
            apl_pkg::APL_IDLE: begin
                if (link_sync) begin
                    next_state = apl_pkg::APL_REQ;
                end
            end
            apl_pkg::APL_REQ: begin
                next_req = 1'b1;
                next_state = apl_pkg::APL_WAIT;
            end
            apl_pkg::APL_WAIT: begin
                if (got_early) begin
                    // axis type from fixed parameter 1 bit 0
                    if (!cfg_i.fixed_param1[apl_pkg::AXIS_TYPE_BIT]) begin
                        next_mode = apl_pkg::APL_AXIS_FINITE;
                    end else if (cfg_i.simple_inf_en) begin
                        next_mode = apl_pkg::APL_AXIS_SIMPLE_INF;
                    end else begin
                        next_mode = apl_pkg::APL_AXIS_PLAIN_INF;
                    end
                    // turns x pulses_per_rev + initial pulse offset, signed turns
                    next_acc = PW'($signed(held.multi_turn) * $signed({1'b0, cfg_i.pulses_per_rev}))
                        + PW'(held.initial_pulse_offset);
                    next_step = 2'd0;
                    next_state = apl_pkg::APL_CALC;
                end
            end
            apl_pkg::APL_CALC: begin
                unique case (step)
                    2'd0: begin
                        // electronic gear: multiply then divide by magnitude
                        next_neg = acc[PW-1];
                        next_acc = PW'((acc[PW-1] ? -acc : acc) * PW'(cfg_i.gear_num));
                        div_a = next_acc;
                        div_b = PW'(cfg_i.gear_den);
                        div_start = 1'b1;
                        next_step = 2'd1;
                    end
                    2'd1: begin
                        if (div_done) begin
                            next_pos = POS_W'(neg ? -div_q : div_q) + cfg_i.home_offset_param;
                            next_step = (mode == apl_pkg::APL_AXIS_FINITE) ? 2'd3 : 2'd2;
                        end
                    end
                    2'd2: begin
                        // infinite axis folds into one rotation span
                        div_a = PW'(next_pos);
                        div_b = PW'(cfg_i.wrap_len);
                        div_start = 1'b1;
                        next_step = 2'd3;
                        next_acc = '0;
                    end
                    2'd3: begin
                        if (mode == apl_pkg::APL_AXIS_FINITE) begin
                            next_valid = 1'b1;
                            next_state = apl_pkg::APL_DONE;
                        end else if (div_done) begin
                            next_pos = POS_W'(div_r);
                            next_valid = 1'b1;
                            next_state = apl_pkg::APL_DONE;
                        end
                    end
                endcase
            end
            apl_pkg::APL_DONE: begin
                next_auto_ok = 1'b1;
                if (!link_sync) begin
                    next_state = apl_pkg::APL_IDLE;
                    next_valid = 1'b0;
                    next_auto_ok = 1'b0;
                    next_got_early = 1'b0;
                end
            end
            default: next_state = apl_pkg::APL_IDLE;
        endcase
        if (home_return_cmd_i && state == apl_pkg::APL_DONE && link_sync) begin
            next_auto_ok = 1'b1;
        end
        next_busy = (next_state == apl_pkg::APL_CALC);
    end

    always_ff @(posedge clock_i or posedge rst_i) begin
        if (rst_i) begin
            state <= apl_pkg::APL_IDLE;
            held <= {apl_pkg::TURN_RESET, apl_pkg::PULSE_RESET};
            got_early <= 1'b0;
            req <= 1'b0;
            step <= 2'd0;
            acc <= '0;
            pos <= apl_pkg::POS_RESET;
            valid <= 1'b0;
            auto_ok <= 1'b0;
            mode <= apl_pkg::APL_AXIS_FINITE;
            neg <= 1'b0;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            held <= next_held;
            got_early <= next_got_early;
            req <= next_req;
            step <= next_step;
            acc <= next_acc;
            pos <= next_pos;
            valid <= next_valid;
            auto_ok <= next_auto_ok;
            mode <= next_mode;
            neg <= next_neg;
            busy <= next_busy;
        end
    end

    assign abs_data_req_o = req;
    assign machine_pos_o = pos;
    assign coord_valid_o = valid;
    assign auto_run_ok_o = auto_ok;
    assign axis_mode_o = mode;
    assign busy_o = busy;
endmodule : apl_absolute_position_loader

// ==== tb/apl_loader_sva.sv ====
module apl_loader_sva #(
    parameter int POS_W = 32
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic link_up_i,
    input wire logic abs_data_valid_i,
    input wire apl_pkg::apl_abs_data_s abs_data_i,
    input wire apl_pkg::apl_cfg_s cfg_i,
    input wire logic home_return_cmd_i,
    input wire logic abs_data_req_o,
    input wire logic [POS_W-1:0] machine_pos_o,
    input wire logic coord_valid_o,
    input wire logic auto_run_ok_o,
    input wire apl_pkg::apl_axis_e axis_mode_o,
    input wire logic busy_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // ==========================================
    // load sequence
    a_req_after_link: assert property ($rose(link_up_i) |-> ##[2:6] abs_data_req_o)
        else $error("no data request after link came up");
    a_req_one_cycle: assert property (abs_data_req_o |=> !abs_data_req_o)
        else $error("data request longer than one cycle");
    a_calc_bounded: assert property ($rose(busy_o) |-> ##[1:200] coord_valid_o)
        else $error("position not ready in time");
    a_busy_not_valid: assert property (busy_o |-> !coord_valid_o)
        else $error("valid while still calculating");
    a_pos_held: assert property (coord_valid_o && $past(coord_valid_o) |-> $stable(machine_pos_o))
        else $error("position moved while valid");
    a_link_clears: assert property (!link_up_i [*4] |-> !coord_valid_o && !auto_run_ok_o)
        else $error("valid kept without link");
    a_auto_follows: assert property ($rose(coord_valid_o) |=> auto_run_ok_o)
        else $error("automatic run not allowed after load");
    a_auto_needs_valid: assert property ($rose(auto_run_ok_o) |-> coord_valid_o)
        else $error("automatic run allowed without coordinates");
    a_mode_type: assert property (coord_valid_o |->
        ((axis_mode_o == apl_pkg::APL_AXIS_FINITE) == !cfg_i.fixed_param1[0]))
        else $error("axis type not taken from bit 0");
    a_mode_variant: assert property (coord_valid_o && cfg_i.fixed_param1[0] |->
        axis_mode_o == (cfg_i.simple_inf_en ? apl_pkg::APL_AXIS_SIMPLE_INF : apl_pkg::APL_AXIS_PLAIN_INF))
        else $error("infinite variant wrong");

    c_finite: cover property ($rose(coord_valid_o) && axis_mode_o == apl_pkg::APL_AXIS_FINITE);
    c_simple: cover property ($rose(coord_valid_o) && axis_mode_o == apl_pkg::APL_AXIS_SIMPLE_INF);
    c_plain: cover property ($rose(coord_valid_o) && axis_mode_o == apl_pkg::APL_AXIS_PLAIN_INF);
endmodule : apl_loader_sva

bind apl_absolute_position_loader apl_loader_sva #(.POS_W(POS_W)) u_sva (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .link_up_i(link_up_i),
    .abs_data_valid_i(abs_data_valid_i),
    .abs_data_i(abs_data_i),
    .cfg_i(cfg_i),
    .home_return_cmd_i(home_return_cmd_i),
    .abs_data_req_o(abs_data_req_o),
    .machine_pos_o(machine_pos_o),
    .coord_valid_o(coord_valid_o),
    .auto_run_ok_o(auto_run_ok_o),
    .axis_mode_o(axis_mode_o),
    .busy_o(busy_o)
);

// ==== tb/apl_drive_model.sv ====
// drive side: answers the data request, or answers on link-up when it read the encoder first
module apl_drive_model (
    input wire logic clock_i,
    input wire logic link_up_i,
    input wire logic abs_data_req_i,
    input wire logic early_i,
    input wire logic [3:0] delay_i,
    input wire apl_pkg::apl_abs_data_s enc_i,
    output logic abs_data_valid_o,
    output apl_pkg::apl_abs_data_s abs_data_o
);
    timeunit 1ns;
    timeprecision 100ps;
    apl_pkg::apl_abs_data_s last = '0;
    initial abs_data_valid_o = 1'b0;
    initial abs_data_o = '1;

    task automatic answer();
        last = enc_i;
        abs_data_o = last;
        abs_data_valid_o = 1'b1;
        @(negedge clock_i);
        abs_data_valid_o = 1'b0;
        // after the answer only incremental feedback follows, no further absolute data
        abs_data_o = ~last;
    endtask : answer

    always begin
        @(negedge clock_i);
        if (early_i && link_up_i) begin
            answer();
            wait (!link_up_i);
        end else if (!early_i && abs_data_req_i) begin
            repeat (delay_i) @(negedge clock_i);
            answer();
        end
    end
endmodule : apl_drive_model

// ==== tb/tb_absolute_position_loader.sv ====
module tb_absolute_position_loader;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic link_up_i = 1'b0;
    logic home_return_cmd_i = 1'b0;
    logic early = 1'b0;
    logic [3:0] delay = 4'h0;
    apl_pkg::apl_cfg_s cfg_i = '0;
    apl_pkg::apl_abs_data_s enc = '0;
    logic abs_data_valid_i;
    apl_pkg::apl_abs_data_s abs_data_i;
    logic abs_data_req_o;
    logic [31:0] machine_pos_o;
    logic coord_valid_o;
    logic auto_run_ok_o;
    apl_pkg::apl_axis_e axis_mode_o;
    logic busy_o;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;

    always #2.5 clock_i = ~clock_i;

    apl_absolute_position_loader dut (.clock_i(clock_i), .rst_i(rst_i), .link_up_i(link_up_i),
        .abs_data_valid_i(abs_data_valid_i), .abs_data_i(abs_data_i), .cfg_i(cfg_i),
        .home_return_cmd_i(home_return_cmd_i), .abs_data_req_o(abs_data_req_o),
        .machine_pos_o(machine_pos_o), .coord_valid_o(coord_valid_o), .auto_run_ok_o(auto_run_ok_o),
        .axis_mode_o(axis_mode_o), .busy_o(busy_o));
    apl_drive_model drive (.clock_i(clock_i), .link_up_i(link_up_i), .abs_data_req_i(abs_data_req_o),
        .early_i(early), .delay_i(delay), .enc_i(enc), .abs_data_valid_o(abs_data_valid_i),
        .abs_data_o(abs_data_i));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    always @(posedge clock_i) begin
        cycles++;
        if (cycles >= 20000) begin
            n_fail++;
            end_sim();
        end
    end

    // expected machine position, truncation toward zero; an infinite axis folds after the offset is added
    function automatic logic [31:0] exp_pos(input apl_pkg::apl_abs_data_s d, input apl_pkg::apl_cfg_s c);
        longint unsigned p;
        logic [31:0] r;
        p = longint'(d.multi_turn) * c.pulses_per_rev + d.initial_pulse_offset;
        p = p * c.gear_num / c.gear_den;
        r = 32'(p) + c.home_offset_param;
        if (c.fixed_param1[0]) r = r % c.wrap_len;
        return r;
    endfunction : exp_pos

    // one power-on load: link up, one request, position and mode checked
    task automatic load(input apl_pkg::apl_axis_e mode);
        int reqs;
        int n;
        int busy_seen;
        reqs = 0;
        busy_seen = 0;
        link_up_i = 1'b0;
        repeat (8) @(negedge clock_i);
        link_up_i = 1'b1;
        for (n = 0; n < 400 && coord_valid_o !== 1'b1; n++) begin
            @(negedge clock_i);
            if (abs_data_req_o === 1'b1) reqs++;
            if (busy_o === 1'b1) busy_seen++;
        end
        check(reqs, 1);
        check(coord_valid_o, 1'b1);
        check(busy_seen != 0, 1'b1);
        check(busy_o, 1'b0);
        check(machine_pos_o, exp_pos(enc, cfg_i));
        check(axis_mode_o, mode);
        @(negedge clock_i);
        check(auto_run_ok_o, 1'b1);
    endtask : load

    task automatic t_finite();
        cfg_i = '{16'h0000, 1'b0, 32'h0000_1000, 16'h0003, 16'h0002, 32'h0000_0100, 32'h0000_3000};
        // initial pulses stand for the index position captured when the encoder was set up
        enc = '{16'h0003, 24'h00_0123};
        delay = 4'h3;
        load(apl_pkg::APL_AXIS_FINITE);
    endtask : t_finite

    task automatic t_slow_cleared_turns();
        // encoder set up again: turns cleared, initial pulses kept
        enc = '{16'h0000, 24'h00_0123};
        delay = 4'hC;
        load(apl_pkg::APL_AXIS_FINITE);
    endtask : t_slow_cleared_turns

    task automatic t_early_answer();
        early = 1'b1;
        enc = '{16'h0002, 24'h00_0040};
        load(apl_pkg::APL_AXIS_FINITE);
        early = 1'b0;
    endtask : t_early_answer

    task automatic t_infinite(input logic simple);
        // configuration changes only once the old coordinates are gone
        link_up_i = 1'b0;
        repeat (8) @(negedge clock_i);
        cfg_i = '{16'h0001, simple, 32'h0000_1000, 16'h0001, 16'h0001, 32'h0000_0100, 32'h0000_3000};
        enc = '{16'h0005, 24'h00_0010};
        delay = 4'h1;
        load(simple ? apl_pkg::APL_AXIS_SIMPLE_INF : apl_pkg::APL_AXIS_PLAIN_INF);
    endtask : t_infinite

    task automatic t_link_drop();
        home_return_cmd_i = 1'b1;
        @(negedge clock_i);
        link_up_i = 1'b0;
        home_return_cmd_i = 1'b0;
        repeat (6) @(negedge clock_i);
        check(coord_valid_o, 1'b0);
        check(auto_run_ok_o, 1'b0);
    endtask : t_link_drop

    initial begin
        repeat (20) @(negedge clock_i);
        rst_i = 1'b0;
        check(coord_valid_o, 1'b0);
        t_finite();
        t_slow_cleared_turns();
        t_early_answer();
        t_infinite(1'b1);
        t_infinite(1'b0);
        t_link_drop();
        end_sim();
    end
endmodule : tb_absolute_position_loader
